// ### inc/usbpl_pkg.sv
// package for the strobe-bus uart pin logic
package usbpl_pkg;
  // register select values (chosen map)
  localparam logic [3:0] USBPL_A_MODE = 4'h0;
  localparam logic [3:0] USBPL_A_STAT = 4'h1;
  localparam logic [3:0] USBPL_A_CMD = 4'h2;
  localparam logic [3:0] USBPL_A_TXD = 4'h3;
  localparam logic [3:0] USBPL_A_IPR = 4'h4;
  localparam logic [3:0] USBPL_A_ISR = 4'h5;
  localparam logic [3:0] USBPL_A_IMR = 4'h6;
  localparam logic [3:0] USBPL_A_OUT_PORT_CONFIG_REG = 4'h7;
  localparam logic [3:0] USBPL_A_OPSET = 4'h8;
  localparam logic [3:0] USBPL_A_OPCLR = 4'h9;
  localparam logic [3:0] USBPL_A_RXD = 4'hA;
  // reset values
  localparam logic [7:0] USBPL_RST_ZERO = 8'h00;
  localparam logic [7:0] USBPL_OUT_IDLE = 8'hFF;
  // status bit positions
  localparam int USBPL_SR_TXRDY = 2;
  localparam int USBPL_SR_RXRDY = 0;
  // irq status bit positions
  localparam int USBPL_ISR_TX = 0;
  localparam int USBPL_ISR_RX = 1;
  localparam int USBPL_ISR_COS = 7;
  // command codes in cmd register
  localparam logic [1:0] USBPL_CMD_TXEN = 2'h1;
  localparam logic [1:0] USBPL_CMD_RXEN = 2'h2;
  // out_port_config_reg fields
  localparam int USBPL_OUT_PORT_CONFIG_REG_RTS = 0;
  localparam int USBPL_OUT_PORT_CONFIG_REG_OP2L = 1;
  localparam int USBPL_OUT_PORT_CONFIG_REG_OP4 = 4;
  localparam int USBPL_OUT_PORT_CONFIG_REG_OP6 = 6;
  localparam int USBPL_OUT_PORT_CONFIG_REG_LOOP = 7;
  localparam logic [1:0] USBPL_OP2_TX16 = 2'h1;
  localparam logic [1:0] USBPL_OP2_TX1 = 2'h2;
  localparam logic [1:0] USBPL_OP2_RX1 = 2'h3;
  // mode register fields, timer enable bit of cmd, data width and divider end
  localparam int USBPL_MR_CTS = 0;
  localparam int USBPL_MR_TXC = 1;
  localparam int USBPL_MR_RXC = 2;
  localparam int USBPL_MR_CTC = 3;
  localparam int USBPL_DBITS = 8;
  localparam logic [3:0] USBPL_OVS = 4'hF;
  // host bus request group
  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [3:0] register_select;
  } usbpl_bus_s;
endpackage

// ### hdl/usbpl_edge.sv
// edge detector for a synchronous pin
`timescale 1ns/1ns
module usbpl_edge (
  // clocking
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // pin in, edges out
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic prev_q;
  logic prev_d;

  // next value is the current pin
  always_comb begin
    prev_d = ce ? pin : prev_q;
  end

  // idle level high so a high-held pin shows no false edge later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = ce & pin & ~prev_q;
  assign fall = ce & ~pin & prev_q;
endmodule // usbpl_edge

// ### hdl/usbpl_serial.sv
// bit shifter for one serial direction, lsb first
`timescale 1ns/1ns
module usbpl_serial #(
  parameter int DBITS = 8
) (
  // clocking
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic [DBITS-1:0] load,
  input wire logic sin,
  // state
  output logic busy,
  output logic done,
  output logic sout,
  output logic [DBITS-1:0] word
);
  logic [DBITS+1:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic done_q, done_d;

  // shift frame: start, data, stop
  always_comb begin
    sh_d = sh_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (ce) begin
      if (start && cnt_q == 4'h0) begin
        sh_d = {1'b1, load, 1'b0};
        cnt_d = 4'(DBITS + 2);
      end else if (tick && cnt_q != 4'h0) begin
        sh_d = {sin, sh_q[DBITS+1:1]};
        cnt_d = cnt_q - 4'h1;
        done_d = (cnt_q == 4'h1);
      end
    end else begin
      done_d = done_q;
    end
  end

  // idle shifter reads all ones, holding the line at mark
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sh_q <= '1;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != 4'h0);
  assign done = done_q;
  assign sout = sh_q[0] | ~busy;
  assign word = sh_q[DBITS:1];
endmodule // usbpl_serial

// ### hdl/usbpl_top.sv
// strobe-style host port and pin logic of a one-channel uart
// Functional notes
// - strobe bus style chosen only when style pin reads high.
// - chip select low enables transfers; high floats the data bus.
// - write loads addressed register at write strobe rising edge.
// - read drives addressed register from read strobe falling edge.
// - data bus bit zero is the least significant bit.
// - reset clears status, masks, irq status, port value, port config.
// - reset drives outputs high, stops timer, idles channel at mark.
// - open-drain irq low while any masked condition is true.
// - receive lsb first, high is mark, low is space.
// - transmit lsb first; line at mark when disabled, idle or looped.
// - out bit zero: general output or request-to-send, auto dropped.
// - out bit two: general, tx 1x/16x clock or rx 1x clock.
// - out bits four and six mirror rx and tx irq, open drain.
// - in bit zero: general or clear-to-send, with change detect.
// - in bit one: general input with change detect.
// - in bit two: general input with change detect.
// - in bit three tx clock: shift on its falling edge.
// - in bit four rx clock: sample on its rising edge.
// - in bits five, six and out bits odd are plain.
`timescale 1ns/1ns
module usbpl_top #(
  parameter int DBITS = usbpl_pkg::USBPL_DBITS
) (
  // clocking
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // bus style select, high for strobe style
  input wire logic bus_style_sel,
  // host bus
  input wire usbpl_pkg::usbpl_bus_s host_bus,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  // interrupt, open drain
  output logic irq_request_out,
  output logic irq_request_oe,
  // serial line
  input wire logic rx_serial_in,
  output logic tx_serial_out,
  // ports
  input wire logic [6:0] input_port_bits,
  output logic [7:0] output_port_bits,
  output logic [7:0] output_port_oe,
  // counter/timer run state
  output logic timer_running
);
  import usbpl_pkg::*;

  logic [7:0] mode_q, mode_d, sr_q, sr_d, imr_q, imr_d, isr_q, isr_d;
  logic [7:0] opr_q, opr_d, out_port_config_reg_q, out_port_config_reg_d, thr_q, thr_d, rhr_q, rhr_d;
  logic [7:0] rd_q, rd_d;
  logic [1:0] cmd_q, cmd_d;
  logic [3:0] div_q, div_d;
  logic [6:0] ip_q, ip_d;
  logic ctr_q, ctr_d, rts_q, rts_d, oe_q, oe_d;
  // byte written and not yet launched; reset clears status, so the
  // status bit alone cannot tell a fresh byte from an empty register
  logic tx_pend_q, tx_pend_d, tx_wr;
  logic sel, wr_rise, rd_fall, rd_act;
  logic txc_fall, rxc_rise;
  logic tx_tick, rx_tick, x16, tx_start, rx_start;
  logic tx_busy, tx_line, rx_busy, rx_done;
  logic [DBITS-1:0] rx_word;
  logic [3:0] cos;
  logic [7:0] opsel;

  // strobe style only when style pin reads high
  assign sel = bus_style_sel & ~host_bus.chip_select_n;

  // strobe and external clock edges; unused edges left open
  usbpl_edge u_wr (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .pin(host_bus.write_strobe_n), .rise(wr_rise), .fall());
  usbpl_edge u_rd (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .pin(host_bus.read_strobe_n), .rise(), .fall(rd_fall));
  usbpl_edge u_txc (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .pin(input_port_bits[3]), .rise(), .fall(txc_fall));
  usbpl_edge u_rxc (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .pin(input_port_bits[4]), .rise(rxc_rise), .fall());

  // internal 16x divider for the bit clock
  always_comb begin
    div_d = ce ? div_q + 4'h1 : div_q;
  end
  assign x16 = ce & (div_q == USBPL_OVS);
  // external tx clock shifts on its falling edge
  assign tx_tick = mode_q[USBPL_MR_TXC] ? txc_fall : x16;
  // external rx clock samples on its rising edge
  assign rx_tick = mode_q[USBPL_MR_RXC] ? rxc_rise : x16;

  // cts gates transmit start when flow control enabled
  // launch only a byte written since the last launch, into an idle shifter
  assign tx_start = tx_pend_q && !tx_busy && cmd_q[0] &&
    !(mode_q[USBPL_MR_CTS] && input_port_bits[0]);
  assign tx_wr = wr_rise & sel & (host_bus.register_select == USBPL_A_TXD);
  // start bit seen as space on the line
  assign rx_start = cmd_q[1] && !rx_busy && !rx_serial_in;

  usbpl_serial #(.DBITS(DBITS)) u_tx (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .start(tx_start), .tick(tx_tick), .load(thr_q),
    .sin(1'b1), .busy(tx_busy), .done(), .sout(tx_line),
    .word());
  // rx shifts lsb first from the line
  usbpl_serial #(.DBITS(DBITS)) u_rx (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .start(rx_start), .tick(rx_tick), .load('1),
    .sin(rx_serial_in), .busy(rx_busy), .done(rx_done), .sout(),
    .word(rx_word));

  // change of state on inputs zero to three
  assign cos = ip_q[3:0] ^ input_port_bits[3:0];
  assign rd_act = rd_fall & sel;

  // register file next state
  always_comb begin
    mode_d = mode_q;
    sr_d = sr_q;
    imr_d = imr_q;
    isr_d = isr_q;
    opr_d = opr_q;
    out_port_config_reg_d = out_port_config_reg_q;
    thr_d = thr_q;
    rhr_d = rhr_q;
    cmd_d = cmd_q;
    ctr_d = ctr_q;
    ip_d = ip_q;
    rts_d = rts_q;
    tx_pend_d = tx_pend_q;
    if (ce) begin
      ip_d = input_port_bits;
      // clears from reads first, so hardware sets below win
      if (rd_act && host_bus.register_select == USBPL_A_RXD) begin
        sr_d[USBPL_SR_RXRDY] = 1'b0;
        isr_d[USBPL_ISR_RX] = 1'b0;
      end
      if (rd_act && host_bus.register_select == USBPL_A_IPR) begin
        isr_d[USBPL_ISR_COS] = 1'b0;
      end
      // write takes effect at strobe rising edge
      if (wr_rise && sel) begin
        case (host_bus.register_select)
          USBPL_A_MODE: mode_d = host_data_in;
          USBPL_A_CMD: begin
            cmd_d = host_data_in[1:0];
            ctr_d = host_data_in[USBPL_MR_CTC];
          end
          USBPL_A_TXD: begin
            thr_d = host_data_in;
            sr_d[USBPL_SR_TXRDY] = 1'b0;
            isr_d[USBPL_ISR_TX] = 1'b0;
          end
          USBPL_A_IMR: imr_d = host_data_in;
          USBPL_A_OUT_PORT_CONFIG_REG: out_port_config_reg_d = host_data_in;
          USBPL_A_OPSET: opr_d = opr_q | host_data_in;
          USBPL_A_OPCLR: opr_d = opr_q & ~host_data_in;
          default: ;
        endcase
      end
      if (tx_start) begin
        sr_d[USBPL_SR_TXRDY] = 1'b1;
        isr_d[USBPL_ISR_TX] = 1'b1;
      end
      if (rx_done) begin
        rhr_d = rx_word;
        sr_d[USBPL_SR_RXRDY] = 1'b1;
        isr_d[USBPL_ISR_RX] = 1'b1;
      end
      if (|cos) begin
        isr_d[USBPL_ISR_COS] = 1'b1;
      end
      // rts asserted while rx enabled, dropped once tx drains
      rts_d = ~(cmd_q[1] | tx_busy);
      // a byte written in the launch cycle stays pending for the next
      if (tx_start) begin
        tx_pend_d = 1'b0;
      end
      if (tx_wr) begin
        tx_pend_d = 1'b1;
      end
    end
  end

  // reset clears registers and idles everything
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= USBPL_RST_ZERO;
      sr_q <= USBPL_RST_ZERO;
      imr_q <= USBPL_RST_ZERO;
      isr_q <= USBPL_RST_ZERO;
      opr_q <= USBPL_RST_ZERO;
      out_port_config_reg_q <= USBPL_RST_ZERO;
      thr_q <= USBPL_RST_ZERO;
      rhr_q <= USBPL_RST_ZERO;
      cmd_q <= 2'h0;
      ctr_q <= 1'b0;
      div_q <= 4'h0;
      ip_q <= 7'h7F;
      rts_q <= 1'b1;
      tx_pend_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      sr_q <= sr_d;
      imr_q <= imr_d;
      isr_q <= isr_d;
      opr_q <= opr_d;
      out_port_config_reg_q <= out_port_config_reg_d;
      thr_q <= thr_d;
      rhr_q <= rhr_d;
      cmd_q <= cmd_d;
      ctr_q <= ctr_d;
      div_q <= div_d;
      ip_q <= ip_d;
      rts_q <= rts_d;
      tx_pend_q <= tx_pend_d;
    end
  end

  // read data captured at read strobe falling edge
  // bit zero of each value lands on bus bit zero
  always_comb begin
    rd_d = rd_q;
    if (rd_act) begin
      case (host_bus.register_select)
        USBPL_A_MODE: rd_d = mode_q;
        USBPL_A_STAT: rd_d = sr_q;
        USBPL_A_IPR: rd_d = {1'b0, input_port_bits};
        USBPL_A_ISR: rd_d = isr_q;
        USBPL_A_IMR: rd_d = imr_q;
        USBPL_A_OUT_PORT_CONFIG_REG: rd_d = out_port_config_reg_q;
        USBPL_A_RXD: rd_d = rhr_q;
        default: rd_d = USBPL_RST_ZERO;
      endcase
    end
  end

  // drive bus while selected and read strobe low
  always_comb begin
    oe_d = oe_q;
    if (ce) begin
      oe_d = sel & ~host_bus.read_strobe_n & (rd_act | oe_q);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_q <= USBPL_RST_ZERO;
      oe_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      oe_q <= oe_d;
    end
  end

  // data floats unless chip select and read are low
  assign host_data_out = rd_q;
  assign host_data_oe = oe_q & sel;

  // never drives high; the board pull-up gives the released level
  // irq pulled low while any masked condition is true
  assign irq_request_out = 1'b0;
  assign irq_request_oe = |(isr_q & imr_q);

  // loop mode only masks the line, the shifter keeps its place
  // line at mark when disabled, idle or in local loop
  assign tx_serial_out = (out_port_config_reg_q[USBPL_OUT_PORT_CONFIG_REG_LOOP] | ~cmd_q[0]) ? 1'b1 :
    tx_line;

  // timer runs only when enabled; stopped by reset
  assign timer_running = ctr_q;

  // output port mux, pin level is inverse of port register bit
  always_comb begin
    opsel = ~opr_q;
    // rts on out bit zero, active low
    if (out_port_config_reg_q[USBPL_OUT_PORT_CONFIG_REG_RTS]) begin
      opsel[0] = rts_q;
    end
    case (out_port_config_reg_q[USBPL_OUT_PORT_CONFIG_REG_OP2L +: 2])
      USBPL_OP2_TX16: opsel[2] = div_q[3];
      USBPL_OP2_TX1: opsel[2] = tx_tick;
      USBPL_OP2_RX1: opsel[2] = rx_tick;
      default: opsel[2] = ~opr_q[2];
    endcase
    // rx and tx irq mirrors, low when active
    if (out_port_config_reg_q[USBPL_OUT_PORT_CONFIG_REG_OP4]) begin
      opsel[4] = 1'b0;
    end
    if (out_port_config_reg_q[USBPL_OUT_PORT_CONFIG_REG_OP6]) begin
      opsel[6] = 1'b0;
    end
  end

  // outputs high after reset; odd bits plain outputs
  // open-drain bits drive only when their irq bit is set
  always_comb begin
    output_port_bits = opsel;
    output_port_oe = USBPL_OUT_IDLE;
    if (out_port_config_reg_q[USBPL_OUT_PORT_CONFIG_REG_OP4]) begin
      output_port_oe[4] = isr_q[USBPL_ISR_RX];
    end
    if (out_port_config_reg_q[USBPL_OUT_PORT_CONFIG_REG_OP6]) begin
      output_port_oe[6] = isr_q[USBPL_ISR_TX];
    end
  end
endmodule // usbpl_top

// ### testbench/usbpl_checker.sv
// port-level assertions for the strobe-bus uart pin logic
`timescale 1ns/1ns
module usbpl_checker (
  // clocking
  input wire logic clk_sys,
  input wire logic rst,
  // host side
  input wire logic bus_style_sel,
  input wire usbpl_pkg::usbpl_bus_s host_bus,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  // pins
  input wire logic irq_request_out,
  input wire logic irq_request_oe,
  input wire logic tx_serial_out,
  input wire logic [7:0] output_port_bits,
  input wire logic timer_running
);
  import usbpl_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // reset state is checked while reset is high, so no disable here
  a_reset_pin_state: assert property (disable iff (1'b0)
    rst |-> tx_serial_out && output_port_bits == 8'hFF && !timer_running)
    else $error("pin state wrong in reset");
  a_irq_off_reset: assert property (disable iff (1'b0)
    rst |-> !irq_request_oe)
    else $error("irq pulled low in reset");
  a_deselect_float: assert property (
    host_bus.chip_select_n |-> !host_data_oe)
    else $error("bus driven while deselected");
  a_style_off_float: assert property (
    !bus_style_sel |-> !host_data_oe)
    else $error("bus driven with style off");
  a_drive_needs_read: assert property (
    host_data_oe |-> !$past(host_bus.read_strobe_n))
    else $error("bus driven without read strobe");
  a_read_answers: assert property (
    $fell(host_bus.read_strobe_n) && !host_bus.chip_select_n
    && bus_style_sel |-> ##[1:2] host_data_oe)
    else $error("read not answered");
  a_read_data_holds: assert property (
    host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
    else $error("read data moved");
  a_read_release: assert property (
    $rose(host_bus.read_strobe_n) |-> ##[0:1] !host_data_oe)
    else $error("bus not released");
  a_irq_open_drain: assert property (
    irq_request_out == 1'b0)
    else $error("irq pin driven high");
  a_mark_after_reset: assert property (
    $fell(rst) |-> tx_serial_out && output_port_bits == 8'hFF)
    else $error("line not idle after reset");
endmodule // usbpl_checker

bind usbpl_top usbpl_checker i_usbpl_checker (.clk_sys, .rst,
  .bus_style_sel, .host_bus, .host_data_out, .host_data_oe,
  .irq_request_out, .irq_request_oe, .tx_serial_out, .output_port_bits,
  .timer_running);

// ### testbench/usbpl_host.sv
// host processor model on the strobe-style bus
`timescale 1ns/1ns
module usbpl_host (
  // clocking
  input wire logic clk_sys,
  // request to the device
  output usbpl_pkg::usbpl_bus_s host_bus,
  output logic [7:0] host_data_in,
  // answer
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe
);
  import usbpl_pkg::*;
  int hold = 2; // strobe level time; raise it for a slow host
  initial begin
    host_bus = '{1'b1, 1'b1, 1'b1, 4'hF};
    host_data_in = 8'h00;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v,
                    input logic cs_n = 1'b0);
    host_bus.chip_select_n <= cs_n;
    host_bus.register_select <= a;
    host_data_in <= v;
    host_bus.write_strobe_n <= 1'b0;
    repeat (hold) @(posedge clk_sys);
    host_bus.write_strobe_n <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    host_bus.chip_select_n <= 1'b1;
    host_data_in <= ~v; // released bus must not keep the old value
    @(posedge clk_sys);
  endtask
  // read cycle, bounded wait for the device to drive
  task automatic rd(input logic [3:0] a, output logic [7:0] v,
                    output logic ok);
    int n;
    n = 0;
    host_bus.chip_select_n <= 1'b0;
    host_bus.register_select <= a;
    @(posedge clk_sys);
    host_bus.read_strobe_n <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((host_data_oe !== 1'b1 || n < hold) && n < 8);
    v = host_data_out;
    ok = host_data_oe === 1'b1;
    host_bus.read_strobe_n <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    host_bus.chip_select_n <= 1'b1;
    @(posedge clk_sys);
  endtask
endmodule // usbpl_host

// ### testbench/testbench.sv
// self-checking bench for the strobe-bus uart pin logic
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  import usbpl_pkg::*;
  logic clk_sys, rst, ce, bus_style_sel, rx_serial_in, ok;
  logic host_data_oe, irq_request_out, irq_request_oe, tx_serial_out;
  logic timer_running;
  logic [6:0] input_port_bits;
  logic [7:0] host_data_in, host_data_out, output_port_bits, output_port_oe;
  logic [7:0] d;
  logic [9:0] frame;
  logic [8:0] got;
  usbpl_bus_s host_bus;
  int n_errors = 0;
  int tests_run = 0;
  int n;
  logic [3:0] regs[5] = '{USBPL_A_STAT, USBPL_A_ISR, USBPL_A_IMR,
                          USBPL_A_OUT_PORT_CONFIG_REG, 4'hF};
  logic [7:0] pat[3] = '{8'h01, 8'h80, 8'hA5};
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  usbpl_host i_usbpl_host (.clk_sys, .host_bus, .host_data_in,
    .host_data_out, .host_data_oe);
  usbpl_top i_usbpl_top (.clk_sys, .rst, .ce, .bus_style_sel, .host_bus,
    .host_data_in, .host_data_out, .host_data_oe, .irq_request_out,
    .irq_request_oe, .rx_serial_in, .tx_serial_out, .input_port_bits,
    .output_port_bits, .output_port_oe, .timer_running);
  // verdict and end of run
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // read one register and compare; a missing answer ends the run
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    i_usbpl_host.rd(a, d, ok);
    `CHK("read answer", 1'b1, ok)
    if (!ok) summarize();
    `CHK("read data", e, d)
  endtask
  // one external clock period: fall, then rise at mid-bit
  task automatic pulse(input int b);
    input_port_bits[b] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    input_port_bits[b] <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    bus_style_sel = 1'b1;
    rx_serial_in = 1'b1;
    input_port_bits = 7'h7F; // pulled-up idle inputs
    repeat (10) @(posedge clk_sys);
    `CHK("reset out port", 8'hFF, output_port_bits)
    `CHK("reset tx line", 1'b1, tx_serial_out)
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    foreach (regs[i]) rchk(regs[i], 8'h00);
    // prompt and slow hosts alike
    foreach (pat[i]) begin
      i_usbpl_host.hold = 2 + i;
      i_usbpl_host.wr(USBPL_A_IMR, pat[i]);
      rchk(USBPL_A_IMR, pat[i]);
    end
    i_usbpl_host.hold = 2;
    i_usbpl_host.wr(USBPL_A_IMR, 8'h3C, 1'b1);
    bus_style_sel <= 1'b0;
    i_usbpl_host.wr(USBPL_A_IMR, 8'h3C);
    bus_style_sel <= 1'b1;
    rchk(USBPL_A_IMR, 8'hA5);
    i_usbpl_host.wr(USBPL_A_OPSET, 8'hAB);
    `CHK("out set", 8'h54, output_port_bits)
    i_usbpl_host.wr(USBPL_A_OPCLR, 8'hFF);
    `CHK("out clear", 8'hFF, output_port_bits)
    // receive on external clock, rts and rx irq pin on
    i_usbpl_host.wr(USBPL_A_MODE, 8'h06);
    i_usbpl_host.wr(USBPL_A_OUT_PORT_CONFIG_REG, 8'h51);
    i_usbpl_host.wr(USBPL_A_CMD, 8'h03);
    `CHK("rts pin", 1'b0, output_port_bits[0])
    frame = {1'b1, 8'hC3, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_serial_in <= frame[i];
      pulse(4);
    end
    `CHK("rx irq pin", 2'b10, {output_port_oe[4], output_port_bits[4]})
    `CHK("masked irq", 1'b0, irq_request_oe)
    rchk(USBPL_A_ISR, 8'h02);
    rchk(USBPL_A_RXD, 8'hC3);
    // transmit on external clock, tx irq pin and irq output
    i_usbpl_host.wr(USBPL_A_OUT_PORT_CONFIG_REG, 8'h40);
    i_usbpl_host.wr(USBPL_A_TXD, 8'h96);
    `CHK("tx irq pin", 2'b10, {output_port_oe[6], output_port_bits[6]})
    `CHK("irq raised", 1'b1, irq_request_oe)
    n = 0;
    while (tx_serial_out !== 1'b0 && n < 20) begin
      pulse(3);
      n++;
    end
    `CHK("start bit", 1'b0, tx_serial_out)
    if (n == 20) summarize();
    for (int i = 0; i < 9; i++) begin
      pulse(3);
      got[i] = tx_serial_out;
    end
    `CHK("tx frame", {1'b1, 8'h96}, got)
    pulse(3);
    `CHK("tx idle after stop", 1'b1, tx_serial_out)
    i_usbpl_host.rd(USBPL_A_ISR, d, ok);
    `CHK("tx clock change", 1'b1, d[7])
    `CHK("tx isr word", 8'h81, d)
    i_usbpl_host.wr(USBPL_A_IMR, 8'h00);
    `CHK("irq masked", 1'b0, irq_request_oe)
    rchk(USBPL_A_IPR, 8'h7F);
    input_port_bits[1] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    i_usbpl_host.rd(USBPL_A_ISR, d, ok);
    `CHK("in one change", 1'b1, d[7])
    // cts flow control holds a written byte back
    i_usbpl_host.wr(USBPL_A_MODE, 8'h07);
    i_usbpl_host.wr(USBPL_A_TXD, 8'h5A);
    `CHK("cts holds tx", 1'b1, tx_serial_out)
    input_port_bits[0] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("cts releases tx", 1'b0, tx_serial_out)
    // local loop holds the line at mark mid-frame; op2 as 16x clock
    i_usbpl_host.wr(USBPL_A_OUT_PORT_CONFIG_REG, 8'h82);
    `CHK("loop line mark", 1'b1, tx_serial_out)
    d[0] = output_port_bits[2];
    repeat ((USBPL_OVS + 1) / 2) @(posedge clk_sys);
    `CHK("tx 16x clock", ~d[0], output_port_bits[2])
    // clock enable low freezes the divider
    ce <= 1'b0;
    @(posedge clk_sys);
    d[1] = output_port_bits[2];
    repeat ((USBPL_OVS + 1) / 2) @(posedge clk_sys);
    `CHK("frozen 16x clock", d[1], output_port_bits[2])
    ce <= 1'b1;
    i_usbpl_host.wr(USBPL_A_OUT_PORT_CONFIG_REG, 8'h00);
    `CHK("loop off start bit", 1'b0, tx_serial_out)
    repeat (10) pulse(3);
    `CHK("cts frame end", 1'b1, tx_serial_out)
    i_usbpl_host.wr(USBPL_A_OUT_PORT_CONFIG_REG, 8'h01);
    i_usbpl_host.wr(USBPL_A_CMD, 8'h08);
    `CHK("timer run", 1'b1, timer_running)
    `CHK("rts dropped", 1'b1, output_port_bits[0])
    `CHK("tx off mark", 1'b1, tx_serial_out)
    // second reset in mid-run
    rst <= 1'b1;
    @(posedge clk_sys);
    `CHK("timer stop", 1'b0, timer_running)
    `CHK("out port high", 8'hFF, output_port_bits)
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rchk(USBPL_A_OUT_PORT_CONFIG_REG, 8'h00);
    summarize();
  end
endmodule // testbench
